// *** rtl/ep1_pkg.sv ***
package ep1_pkg;

    // ****************************************
    // word indices (byte address = 4 * index)
    // ****************************************
    localparam logic [5:0] idx_std_top = 6'h0F;
    localparam logic [5:0] idx_fiber_media = 6'h10;
    localparam logic [5:0] idx_good_crc = 6'h12;
    localparam logic [5:0] idx_ext_mode = 6'h13;
    localparam logic [5:0] idx_page1_hi = 6'h1E;
    localparam logic [5:0] idx_page_select = 6'h1F;
    localparam logic [5:0] idx_irq_status = 6'h20;
    localparam logic [5:0] idx_irq_mask = 6'h21;

    // page select values
    localparam logic [15:0] page_main = 16'h0000;
    localparam logic [15:0] page_ext1 = 16'h0001;

    // ****************************************
    // field positions
    // ****************************************
    localparam int fm_tx_rf_lsb = 14;
    localparam int fm_lp_rf_lsb = 12;
    localparam int fm_allow_1000x = 9;
    localparam int fm_allow_100fx = 8;
    localparam int fm_far_end = 6;
    localparam int gc_since_read = 15;
    localparam int em_led_lsb = 12;
    localparam int em_blink_suppress = 11;
    localparam int em_fast_fail = 4;
    localparam int em_xover_lsb = 2;
    localparam int em_signal_detect_input_pol = 0;

    // interrupt status / mask bits
    localparam int irq_far_end = 0;
    localparam int irq_good_pkt = 1;
    localparam int irq_count_wrap = 2;
    localparam int irq_hold_release = 3;

    // counter wraps after this value
    localparam logic [13:0] count_top = 14'h270F;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        EP1_XOVER_AUTO,
        EP1_XOVER_RESERVED,
        EP1_XOVER_MDI,
        EP1_XOVER_MDIX
    } ep1_xover_t;

    typedef struct packed {
        logic [1:0] tx_remote_fault;
        logic allow_1000x;
        logic allow_100fx;
    } ep1_media_t;

    typedef struct packed {
        logic [3:0] led_extended;
        logic blink_suppress;
        logic fast_link_fail_en;
        ep1_xover_t xover;
        logic signal_detect_input_active_low;
    } ep1_mode_t;

    typedef struct packed {
        logic [15:0] page_q;
        logic [1:0] tx_rf_q;
        logic allow_1000x_q;
        logic allow_100fx_q;
        logic far_end_q;
        logic pkt_since_q;
        logic [13:0] count_q;
        logic [3:0] led_ext_q;
        logic blink_sup_q;
        logic fast_fail_q;
        logic [1:0] xover_q;
        logic signal_detect_input_pol_q;
        logic [3:0] irq_stat_q;
        logic [3:0] irq_mask_q;
        logic [2:0] hold_sync_q;
        logic hold_q;
        logic [3:0] sig_s0_q;
        logic [3:0] sig_s1_q;
        logic [3:0] sig_s2_q;
        logic [3:0] sig_q;
        logic [3:0] sig_act_q;
        logic blink_q;
        logic cap_q;
        logic err_q;
        logic [31:0] prdata_q;
    } ep1_state_t;

    // reset values: both fiber link-up permits start allowed
    localparam ep1_state_t ep1_state_rst = '{
        allow_1000x_q: 1'b1,
        allow_100fx_q: 1'b1,
        default: '0
    };

endpackage : ep1_pkg

// *** rtl/ep1_register_bank.sv ***
// The APB slave port was chosen for this implementation.
`timescale 1ns/1ps

module ep1_register_bank
    import ep1_pkg::*;
#(
    parameter logic [2:0] port_id = 3'h0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic std_sel,
    output logic [4:0] std_addr,
    output logic std_wr_stb,
    output logic std_rd_stb,
    output logic [15:0] std_wdata,
    input wire logic [15:0] std_rdata,
    input wire logic [1:0] link_partner_remote_fault,
    input wire logic far_end_fault_event,
    input wire logic good_crc_packet,
    input wire logic low_power_hold_input,
    input wire logic [3:0] signal_detect_input,
    output ep1_media_t media_out,
    output ep1_mode_t mode_out,
    output logic [3:0] signal_detect_active,
    output logic led_hold_blink,
    output logic irq
);

    // ****************************************
    // address decode
    // ****************************************
    localparam logic serdes_port = (port_id <= 3'h3);
    localparam logic phy_zero = (port_id == 3'h0);

    ep1_state_t st;
    ep1_state_t nx;
    logic [5:0] idx;
    logic aligned;
    logic std_hit;
    logic page1_hit;
    logic own_hit;
    logic mapped;
    logic cap;
    logic done;
    logic wr_ok;
    logic rc_fiber;
    logic rc_crc;
    logic hold_fall;
    logic [15:0] rd_word;
    logic [1:0] wr_xover;
    logic [1:0] wr_tx_rf;
    logic wr_allow_1000x;
    logic wr_allow_100fx;

    assign idx = paddr[7:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign wr_xover = pwdata[em_xover_lsb +: 2];
    // write fields of the fiber media word, named for the checks
    assign wr_tx_rf = pwdata[fm_tx_rf_lsb +: 2];
    assign wr_allow_1000x = pwdata[fm_allow_1000x];
    assign wr_allow_100fx = pwdata[fm_allow_100fx];

    // route by index and page
    always_comb begin
        std_hit = 1'b0;
        page1_hit = 1'b0;
        own_hit = 1'b0;
        if (idx <= idx_std_top) begin
            std_hit = 1'b1;
        end else if (idx <= idx_page1_hi) begin
            if (st.page_q == page_ext1) begin
                page1_hit = 1'b1;
            end else begin
                std_hit = 1'b1;
            end
        end else if (idx == idx_page_select) begin
            own_hit = 1'b1;
        end else if (idx == idx_irq_status) begin
            own_hit = 1'b1;
        end else if (idx == idx_irq_mask) begin
            own_hit = 1'b1;
        end
    end

    assign mapped = aligned && (std_hit || page1_hit || own_hit);

    // ****************************************
    // apb handshake
    // ****************************************
    // first selected cycle of a transfer (setup phase, penable not needed) captures read data
    assign cap = psel && ce && !st.cap_q;
    assign pready = ce && st.cap_q;
    assign done = psel && penable && pready;
    assign wr_ok = done && pwrite && !st.err_q;
    assign prdata = st.prdata_q;
    assign pslverr = st.err_q && pready;

    // read-clear strobes fire at the capture edge
    assign rc_fiber = cap && !pwrite && page1_hit && aligned && (idx == idx_fiber_media);
    assign rc_crc = cap && !pwrite && page1_hit && aligned && (idx == idx_good_crc);

    // standard register space passes outward
    assign std_sel = psel && std_hit && aligned;
    assign std_addr = idx[4:0];
    assign std_wdata = pwdata[15:0];
    assign std_wr_stb = wr_ok && std_hit && aligned;
    assign std_rd_stb = cap && !pwrite && std_hit && aligned;

    // ****************************************
    // read data mux
    // ****************************************
    always_comb begin
        rd_word = 16'h0000;
        if (std_hit) begin
            rd_word = std_rdata;
        end else if (page1_hit) begin
            if (idx == idx_fiber_media) begin
                rd_word[fm_tx_rf_lsb +: 2] = st.tx_rf_q;
                rd_word[fm_lp_rf_lsb +: 2] = link_partner_remote_fault;
                rd_word[fm_allow_1000x] = st.allow_1000x_q;
                rd_word[fm_allow_100fx] = st.allow_100fx_q;
                rd_word[fm_far_end] = st.far_end_q;
            end else if (idx == idx_good_crc) begin
                rd_word[gc_since_read] = st.pkt_since_q;
                rd_word[13:0] = st.count_q;
            end else if (idx == idx_ext_mode) begin
                rd_word[em_led_lsb +: 4] = st.led_ext_q;
                rd_word[em_blink_suppress] = st.blink_sup_q;
                rd_word[em_fast_fail] = st.fast_fail_q;
                rd_word[em_xover_lsb +: 2] = st.xover_q;
                rd_word[em_signal_detect_input_pol] = st.signal_detect_input_pol_q;
            end
        end else if (idx == idx_page_select) begin
            rd_word = st.page_q;
        end else if (idx == idx_irq_status) begin
            rd_word[3:0] = st.irq_stat_q;
        end else if (idx == idx_irq_mask) begin
            rd_word[3:0] = st.irq_mask_q;
        end
    end

    // ****************************************
    // next state
    // ****************************************
    // stable low-power hold going inactive
    assign hold_fall = st.hold_q && (st.hold_sync_q[1] == st.hold_sync_q[2])
        && !st.hold_sync_q[2];

    always_comb begin
        logic [13:0] base;
        logic [3:0] ev;
        logic [3:0] w1c;
        logic [3:0] agree;
        base = 14'h0000;
        ev = 4'h0;
        w1c = 4'h0;
        agree = 4'h0;
        nx = st;

        // bus transfer tracking
        if (cap) begin
            nx.cap_q = 1'b1;
            nx.err_q = !mapped;
            nx.prdata_q = mapped ? {16'h0000, rd_word} : 32'h0000_0000; // refused reads give zero
        end else if (done) begin
            nx.cap_q = 1'b0;
            nx.err_q = 1'b0;
        end

        // register writes at the completion edge
        if (wr_ok && page1_hit) begin
            if (idx == idx_fiber_media) begin
                nx.tx_rf_q = pwdata[fm_tx_rf_lsb +: 2];
                nx.allow_1000x_q = pwdata[fm_allow_1000x];
                nx.allow_100fx_q = pwdata[fm_allow_100fx];
            end else if (idx == idx_ext_mode) begin
                nx.led_ext_q = pwdata[em_led_lsb +: 4];
                nx.blink_sup_q = pwdata[em_blink_suppress];
                nx.fast_fail_q = pwdata[em_fast_fail];
                nx.xover_q = wr_xover;
                nx.signal_detect_input_pol_q = pwdata[em_signal_detect_input_pol];
            end
        end else if (wr_ok && own_hit) begin
            if (idx == idx_page_select) begin
                nx.page_q = pwdata[15:0];
            end else if (idx == idx_irq_status) begin
                w1c = pwdata[3:0];
            end else if (idx == idx_irq_mask) begin
                nx.irq_mask_q = pwdata[3:0];
            end
        end

        // far end fault: clear on read, event wins
        if (rc_fiber) begin
            nx.far_end_q = 1'b0;
        end
        if (far_end_fault_event) begin
            nx.far_end_q = 1'b1;
            ev[irq_far_end] = 1'b1;
        end

        // good packet counter, modulo wrap, clear on read
        base = rc_crc ? 14'h0000 : st.count_q;
        nx.count_q = base;
        if (rc_crc) begin
            nx.pkt_since_q = 1'b0;
        end
        if (good_crc_packet) begin
            nx.pkt_since_q = 1'b1;
            ev[irq_good_pkt] = 1'b1;
            if (base == count_top) begin
                nx.count_q = 14'h0000;
                ev[irq_count_wrap] = 1'b1;
            end else begin
                nx.count_q = base + 14'h0001;
            end
        end

        // low-power hold pin: three stages, second and third must agree
        nx.hold_sync_q = {st.hold_sync_q[1:0], low_power_hold_input};
        if (st.hold_sync_q[1] == st.hold_sync_q[2]) begin
            nx.hold_q = st.hold_sync_q[2];
        end
        nx.blink_q = hold_fall && !st.blink_sup_q;
        ev[irq_hold_release] = hold_fall;

        // signal detect pins with polarity applied
        nx.sig_s0_q = signal_detect_input;
        nx.sig_s1_q = st.sig_s0_q;
        nx.sig_s2_q = st.sig_s1_q;
        agree = ~(st.sig_s1_q ^ st.sig_s2_q);
        nx.sig_q = (agree & st.sig_s2_q) | (~agree & st.sig_q);
        nx.sig_act_q = nx.sig_q ^ {4{nx.signal_detect_input_pol_q}};

        // sticky interrupt status, set wins over clear
        nx.irq_stat_q = (st.irq_stat_q & ~w1c) | ev;
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= ep1_state_rst;
        end else if (ce) begin
            st <= nx;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // fiber controls only on quad ports
    always_comb begin
        media_out.tx_remote_fault = serdes_port ? st.tx_rf_q : 2'h0;
        media_out.allow_1000x = serdes_port && st.allow_1000x_q;
        media_out.allow_100fx = serdes_port && st.allow_100fx_q;
    end

    // mode controls
    always_comb begin
        mode_out.led_extended = st.led_ext_q;
        mode_out.blink_suppress = st.blink_sup_q;
        mode_out.fast_link_fail_en = phy_zero && st.fast_fail_q;
        mode_out.xover = ep1_xover_t'(st.xover_q);
        mode_out.signal_detect_input_active_low = st.signal_detect_input_pol_q;
    end

    assign signal_detect_active = st.sig_act_q;
    assign led_hold_blink = st.blink_q;
    assign irq = |(st.irq_stat_q & st.irq_mask_q);

    // ****************************************
    // checks
    // ****************************************
    sequence page_write_seq(logic [15:0] v);
        cap && pwrite && aligned && idx == idx_page_select && pwdata[15:0] == v
        ##1 done;
    endsequence

    sequence ext_mode_write_seq;
        cap && pwrite && page1_hit && aligned && idx == idx_ext_mode ##1 done;
    endsequence

    sequence fiber_write_seq;
        cap && pwrite && page1_hit && aligned && idx == idx_fiber_media ##1 done;
    endsequence

    chk_page_one_select: assert property (@(posedge pclk) disable iff (!presetn)
        page_write_seq(page_ext1) |=> st.page_q == page_ext1)
        else $error("page select write of one not taken");

    chk_page_main_back: assert property (@(posedge pclk) disable iff (!presetn)
        page_write_seq(page_main) |=> st.page_q == page_main)
        else $error("page select write of zero not taken");

    chk_low_std_route: assert property (@(posedge pclk) disable iff (!presetn)
        psel && aligned && idx <= idx_std_top |-> std_sel)
        else $error("low index not routed to standard space");

    chk_upper_page_route: assert property (@(posedge pclk) disable iff (!presetn)
        psel && st.page_q == page_ext1 && idx > idx_std_top && idx <= idx_page1_hi
        |-> !std_sel && !std_wr_stb)
        else $error("page one access leaked to standard space");

    chk_count_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ce && good_crc_packet && !rc_crc && st.count_q == count_top |=> st.count_q == 14'h0000)
        else $error("good packet counter did not wrap at top");

    chk_read_keeps_event: assert property (@(posedge pclk) disable iff (!presetn)
        rc_crc && good_crc_packet |=> st.count_q == 14'h0001 && st.pkt_since_q)
        else $error("packet lost during counter read");

    chk_since_read_flag: assert property (@(posedge pclk) disable iff (!presetn)
        rc_crc && !good_crc_packet |=> !st.pkt_since_q && prdata[15] == $past(st.pkt_since_q))
        else $error("packet flag not returned then cleared");

    chk_far_end_set: assert property (@(posedge pclk) disable iff (!presetn)
        ce && far_end_fault_event |=> st.far_end_q ##1 (st.far_end_q || $past(rc_fiber)))
        else $error("far end fault not captured");

    chk_xover_write: assert property (@(posedge pclk) disable iff (!presetn)
        ext_mode_write_seq |=> mode_out.xover == ep1_xover_t'($past(wr_xover)))
        else $error("crossover field not applied");

    chk_hold_blink_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        ce && hold_fall && !st.blink_sup_q |=> led_hold_blink)
        else $error("no blink after hold release");

    chk_reserved_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        cap && !pwrite && page1_hit && idx == 6'h11 |=> prdata == 32'h0000_0000)
        else $error("reserved page one index read nonzero");

    chk_tx_fault_write: assert property (@(posedge pclk) disable iff (!presetn)
        fiber_write_seq |=> st.tx_rf_q == $past(wr_tx_rf))
        else $error("transmit remote fault field not applied");

    chk_allow_1000x_write: assert property (@(posedge pclk) disable iff (!presetn)
        fiber_write_seq |=> st.allow_1000x_q == $past(wr_allow_1000x))
        else $error("1000BASE-X permit not applied");

    chk_allow_100fx_write: assert property (@(posedge pclk) disable iff (!presetn)
        fiber_write_seq |=> st.allow_100fx_q == $past(wr_allow_100fx))
        else $error("100BASE-FX permit not applied");

    chk_count_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
        rc_crc && !good_crc_packet |=> st.count_q == 14'h0000)
        else $error("good packet counter not cleared by read");

    chk_refused_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        cap && !mapped |=> prdata == 32'h0000_0000 && st.err_q)
        else $error("refused access returned data");

endmodule : ep1_register_bank

// *** tb/test_extended_page1_register_bank.sv ***
`timescale 1ns/1ps

module test_extended_page1_register_bank
    import ep1_pkg::*;
;
    // ****************************************
    // signals
    // ****************************************
    localparam logic [7:0] a_fm = {idx_fiber_media, 2'b00};
    localparam logic [7:0] a_gc = {idx_good_crc, 2'b00};
    localparam logic [7:0] a_em = {idx_ext_mode, 2'b00};
    localparam logic [7:0] a_pg = {idx_page_select, 2'b00};
    localparam logic [7:0] a_st = {idx_irq_status, 2'b00};
    localparam logic [7:0] a_mk = {idx_irq_mask, 2'b00};
    localparam logic [15:0] std_val = 16'h5AC3;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, std_sel, std_wr_stb, std_rd_stb, led_hold_blink, irq;
    logic [4:0] std_addr;
    logic [15:0] std_wdata, std_rdata = std_val;
    logic [1:0] link_partner_remote_fault = 2'b00;
    logic far_end_fault_event = 1'b0, good_crc_packet = 1'b0, low_power_hold_input = 1'b0;
    logic [3:0] signal_detect_input = 4'h0, signal_detect_active;
    ep1_media_t media_out;
    ep1_mode_t mode_out;
    int errors = 0, n_compared = 0;

    ep1_register_bank dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .std_sel(std_sel), .std_addr(std_addr),
        .std_wr_stb(std_wr_stb), .std_rd_stb(std_rd_stb), .std_wdata(std_wdata),
        .std_rdata(std_rdata), .link_partner_remote_fault(link_partner_remote_fault),
        .far_end_fault_event(far_end_fault_event), .good_crc_packet(good_crc_packet),
        .low_power_hold_input(low_power_hold_input), .signal_detect_input(signal_detect_input),
        .media_out(media_out), .mode_out(mode_out), .signal_detect_active(signal_detect_active),
        .led_hold_blink(led_hold_blink), .irq(irq));

    // 100 MHz clock
    always #5 pclk = ~pclk;

    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one apb transfer, drives and samples at rising edges, waits for pready
    task automatic apb(input logic we, input logic [7:0] addr, input logic [15:0] wd,
                       input logic ev, output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= we;
        paddr <= addr;
        pwdata <= {16'h0000, wd};
        good_crc_packet <= ev;
        @(posedge pclk);
        penable <= 1'b1;
        good_crc_packet <= 1'b0;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] addr, input logic [15:0] wd);
        logic [31:0] rd;
        logic err;
        apb(1'b1, addr, wd, 1'b0, rd, err);
    endtask : wr

    task automatic rdc(input logic [7:0] addr, input logic [31:0] exp, input logic ev = 1'b0);
        logic [31:0] rd;
        logic err;
        apb(1'b0, addr, 16'h0000, ev, rd, err);
        chk($sformatf("reg %h", addr), exp, rd);
        chk("pslverr", 32'h0, {31'h0, err});
    endtask : rdc

    task automatic rde(input logic [7:0] addr);
        logic [31:0] rd;
        logic err;
        apb(1'b0, addr, 16'h0000, 1'b0, rd, err);
        chk("pslverr", 32'h1, {31'h0, err});
        chk("prdata", 32'h0, rd);
    endtask : rde

    // hold an event input high for n edges
    task automatic pulse(input bit crc, input int n);
        @(posedge pclk);
        if (crc) good_crc_packet <= 1'b1;
        else far_end_fault_event <= 1'b1;
        repeat (n) @(posedge pclk);
        good_crc_packet <= 1'b0;
        far_end_fault_event <= 1'b0;
        @(negedge pclk);
    endtask : pulse

    task automatic hold_release(input logic [31:0] exp);
        logic seen;
        seen = 1'b0;
        @(posedge pclk);
        low_power_hold_input <= 1'b1;
        repeat (8) @(posedge pclk);
        low_power_hold_input <= 1'b0;
        repeat (10) begin
            @(negedge pclk);
            if (led_hold_blink === 1'b1) seen = 1'b1;
        end
        chk("led_hold_blink", exp, {31'h0, seen});
    endtask : hold_release

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset_and_page;
        chk("media_out", 32'h3, {28'h0, media_out});
        rdc(a_pg, 32'h0);
        rdc(a_fm, {16'h0, std_val});
        wr(a_pg, page_ext1);
        rdc(a_fm, 32'h0300);
        rdc(a_gc, 32'h0);
        rdc(a_em, 32'h0);
        rdc(8'h14, {16'h0, std_val});
        wr(8'h44, 16'hFFFF);
        rdc(8'h44, 32'h0);
        rdc(8'h78, 32'h0);
        rde(8'h88);
        rde(8'h41);
    endtask : t_reset_and_page

    task automatic t_fiber;
        @(posedge pclk);
        link_partner_remote_fault <= 2'b10;
        wr(a_fm, 16'hFFFF);
        rdc(a_fm, 32'hE300);
        chk("media_out", 32'hF, {28'h0, media_out});
        wr(a_fm, 16'h0000);
        chk("media_out", 32'h0, {28'h0, media_out});
        pulse(1'b0, 1);
        rdc(a_fm, 32'h2040);
        rdc(a_fm, 32'h2000);
    endtask : t_fiber

    task automatic t_counter;
        pulse(1'b1, 5);
        rdc(a_gc, 32'h8005);
        rdc(a_gc, 32'h0);
        wr(a_gc, 16'h1234);
        rdc(a_gc, 32'h0);
        pulse(1'b1, 9999);
        rdc(a_gc, {18'h2, count_top});
        pulse(1'b1, 10000);
        rdc(a_gc, 32'h8000, 1'b1);
        rdc(a_gc, 32'h8001);
    endtask : t_counter

    task automatic t_mode;
        wr(a_em, 16'hFFFF);
        rdc(a_em, 32'hF81D);
        chk("mode_out", 32'h1FF, {23'h0, mode_out});
        for (int c = 0; c < 4; c++) begin
            wr(a_em, {11'h0, 1'b1, c[1:0], 2'b00});
            chk("mode_out", {27'h0, 1'b1, c[1:0], 1'b0}, {23'h0, mode_out});
        end
        wr(a_em, 16'h0000);
        @(posedge pclk);
        signal_detect_input <= 4'h5;
        repeat (6) @(posedge pclk);
        @(negedge pclk);
        chk("signal_detect_active", 32'h5, {28'h0, signal_detect_active});
        wr(a_em, 16'h0001);
        repeat (3) @(negedge pclk);
        chk("signal_detect_active", 32'hA, {28'h0, signal_detect_active});
        hold_release(32'h1);
        wr(a_em, 16'h0800);
        hold_release(32'h0);
    endtask : t_mode

    task automatic t_irq;
        wr(a_st, 16'h000F);
        rdc(a_st, 32'h0);
        pulse(1'b0, 1);
        rdc(a_st, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        wr(a_mk, 16'h0001);
        chk("irq", 32'h1, {31'h0, irq});
        wr(a_st, 16'h0001);
        chk("irq", 32'h0, {31'h0, irq});
        rdc(a_mk, 32'h1);
        wr(a_pg, page_main);
        rdc(a_fm, {16'h0, std_val});
        // clock enable low: an event offered meanwhile is not taken
        @(posedge pclk);
        ce <= 1'b0;
        far_end_fault_event <= 1'b1;
        @(posedge pclk);
        far_end_fault_event <= 1'b0;
        @(posedge pclk);
        ce <= 1'b1;
        @(negedge pclk);
        rdc(a_st, 32'h0);
    endtask : t_irq

    // ****************************************
    // run control
    // ****************************************
    task automatic conclude;
        $display("comparisons %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : conclude

    // main sequence
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        t_reset_and_page();
        t_fiber();
        t_counter();
        t_mode();
        t_irq();
        conclude();
    end

    // watchdog, run needs about 20k cycles, limit 40k
    initial begin
        #400000;
        errors++;
        conclude();
    end

endmodule : test_extended_page1_register_bank
